// ==== adc_defs.svh ====
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH
`define ADC_CLK_PERIOD_NS   10
`define ADC_WAKE_WAIT_US    200
`define ADC_WAKE_CYCLES     ((`ADC_WAKE_WAIT_US * 1000 + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_WAKE_REFRESHES  8
`define ADC_REF_PERIOD_MS   16
`define ADC_REF_ROWS        1024
`define ADC_REF_INTERVAL    ((`ADC_REF_PERIOD_MS * 1000000 / `ADC_REF_ROWS) / `ADC_CLK_PERIOD_NS)
`define ADC_RAS_PRE         4
`define ADC_RAS_CAS         2
`define ADC_CAS_ACCESS      4
`define ADC_CAS_PRE         1
`define ADC_CBR_SETUP       1
`define ADC_CBR_HOLD        5
`endif

// ==== adc_pkg.sv ====
package adc_pkg;
    typedef enum logic [3:0] {
        ST_WAKE    = 4'h0,
        ST_IDLE    = 4'h1,
        ST_ROW     = 4'h2,
        ST_COL     = 4'h3,
        ST_ACCESS  = 4'h4,
        ST_CAS_PRE = 4'h5,
        ST_CBR_CAS = 4'h6,
        ST_CBR_RAS = 4'h7,
        ST_PRE     = 4'h8
    } adc_state_e;

    typedef struct packed {
        logic        write;
        logic [1:0]  byte_en;
        logic [19:0] addr;
        logic [15:0] wdata;
    } adc_req_s;

    typedef struct packed {
        logic        ras_n;
        logic        lower_byte_column_strobe_n;
        logic        upper_byte_column_strobe_n;
        logic        we_n;
        logic        oe_n;
        logic [9:0]  addr;
    } adc_pins_s;
endpackage : adc_pkg

// ==== adc_ctrl.sv ====
`timescale 1ns/100ps
`include "adc_defs.svh"
module adc_ctrl #(
    parameter int WAKE_CYCLES = `ADC_WAKE_CYCLES,
    parameter int REF_INTERVAL = `ADC_REF_INTERVAL
) (
    input  wire logic              clk_in,       // 100 MHz
    input  wire logic              rst_n_in,     // sync reset
    input  wire logic              req_valid_in, // request offered
    input  wire adc_pkg::adc_req_s req_in,       // request fields
    output logic                   req_ready_out,// request taken
    output logic                   rd_valid_out, // read data pulse
    output logic [15:0]            rd_data_out,  // read data
    output logic                   init_done_out,// wake-up done
    output adc_pkg::adc_pins_s     pins_out,     // strobes, address
    output logic [15:0]            dq_out,       // data to device
    output logic                   dq_oe_out,    // drive data pins
    input  wire logic [15:0]       dq_in         // data from device
);
    adc_pkg::adc_state_e state_q;
    adc_pkg::adc_req_s   cur_q;
    logic [31:0]         cnt_q;
    logic [31:0]         ref_cnt_q;
    logic [3:0]          wake_left_q;
    logic                ref_due_q;
    logic                ref_late_q;
    logic [15:0]         dq_s1_q;
    logic [15:0]         dq_s2_q;

    // pins are asynchronous to us
    always_ff @(posedge clk_in) begin
        dq_s1_q <= dq_in;
        dq_s2_q <= dq_s1_q;
    end

    // refresh interval timer; a lapse while a refresh is still due forces the wake-up refreshes again, without the wake wait
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ref_cnt_q  <= 32'h0000_0000;
            ref_due_q  <= 1'b0;
            ref_late_q <= 1'b0;
        end else begin
            if (state_q == adc_pkg::ST_CBR_RAS && cnt_q == 32'h0000_0000) begin
                // an interval ending in this cycle still asks for one more refresh
                ref_due_q  <= (ref_cnt_q >= 32'(REF_INTERVAL - 1));
                ref_late_q <= 1'b0;
                ref_cnt_q  <= 32'h0000_0000;
            end else if (ref_cnt_q >= 32'(REF_INTERVAL - 1)) begin
                ref_cnt_q  <= 32'h0000_0000;
                ref_due_q  <= 1'b1;
                ref_late_q <= ref_due_q;
            end else begin
                ref_cnt_q <= ref_cnt_q + 32'h0000_0001;
            end
        end
    end

    // one cycle at a time; next access waits for full precharge unless it hits the open row with the same kind in page mode
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q       <= adc_pkg::ST_WAKE;
            cnt_q         <= 32'h0000_0000;
            wake_left_q   <= 4'h0;
            cur_q         <= '0;
            init_done_out <= 1'b0;
            req_ready_out <= 1'b0;
            rd_valid_out  <= 1'b0;
            rd_data_out   <= 16'h0000;
            pins_out      <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 10'h000};
            dq_out        <= 16'h0000;
            dq_oe_out     <= 1'b0;
        end else begin
            req_ready_out <= 1'b0;
            rd_valid_out  <= 1'b0;
            case (state_q)
                adc_pkg::ST_WAKE: begin
                    if (cnt_q >= 32'(WAKE_CYCLES - 1)) begin
                        cnt_q       <= 32'h0000_0000;
                        wake_left_q <= 4'(`ADC_WAKE_REFRESHES);
                        state_q     <= adc_pkg::ST_PRE;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                adc_pkg::ST_PRE: begin
                    // both byte strobes and row strobe high clear held data
                    pins_out.ras_n                      <= 1'b1;
                    pins_out.lower_byte_column_strobe_n <= 1'b1;
                    pins_out.upper_byte_column_strobe_n <= 1'b1;
                    pins_out.we_n                       <= 1'b1;
                    pins_out.oe_n                       <= 1'b1;
                    dq_oe_out                           <= 1'b0;
                    if (cnt_q >= 32'(`ADC_RAS_PRE - 1)) begin
                        cnt_q   <= 32'h0000_0000;
                        state_q <= adc_pkg::ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                adc_pkg::ST_IDLE: begin
                    if (ref_late_q && init_done_out) begin
                        init_done_out <= 1'b0;
                        wake_left_q   <= 4'(`ADC_WAKE_REFRESHES);
                    end else if (wake_left_q != 4'h0 || ref_due_q) begin
                        // column strobes fall first; no row address needed
                        pins_out.lower_byte_column_strobe_n <= 1'b0;
                        pins_out.upper_byte_column_strobe_n <= 1'b0;
                        state_q <= adc_pkg::ST_CBR_CAS;
                    end else if (req_valid_in) begin
                        cur_q          <= req_in;
                        req_ready_out  <= 1'b1;
                        pins_out.addr  <= req_in.addr[19:10];
                        state_q        <= adc_pkg::ST_ROW;
                    end
                end
                adc_pkg::ST_CBR_CAS: begin
                    if (cnt_q >= 32'(`ADC_CBR_SETUP - 1)) begin
                        cnt_q          <= 32'h0000_0000;
                        pins_out.ras_n <= 1'b0;
                        state_q        <= adc_pkg::ST_CBR_RAS;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                adc_pkg::ST_CBR_RAS: begin
                    if (cnt_q >= 32'(`ADC_CBR_HOLD - 1)) begin
                        cnt_q   <= 32'h0000_0000;
                        state_q <= adc_pkg::ST_PRE;
                        if (wake_left_q == 4'h1) begin
                            init_done_out <= 1'b1;
                        end
                        if (wake_left_q != 4'h0) begin
                            wake_left_q <= wake_left_q - 4'h1;
                        end
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                adc_pkg::ST_ROW: begin
                    pins_out.ras_n <= 1'b0;
                    // write strobe before column strobe: early write, gate off
                    // never lowered after the column strobe, so no read-write cycle
                    pins_out.we_n  <= ~cur_q.write;
                    pins_out.oe_n  <= cur_q.write;
                    dq_out         <= cur_q.wdata;
                    dq_oe_out      <= cur_q.write;
                    state_q        <= adc_pkg::ST_COL;
                end
                adc_pkg::ST_COL: begin
                    if (cnt_q >= 32'(`ADC_RAS_CAS - 1)) begin
                        cnt_q         <= 32'h0000_0000;
                        pins_out.addr <= cur_q.addr[9:0];
                        state_q       <= adc_pkg::ST_ACCESS;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                adc_pkg::ST_ACCESS: begin
                    pins_out.lower_byte_column_strobe_n <= ~cur_q.byte_en[0];
                    pins_out.upper_byte_column_strobe_n <= ~cur_q.byte_en[1];
                    // read data crosses two sync stages before it is taken
                    if (cnt_q >= 32'(`ADC_CAS_ACCESS)) begin
                        cnt_q        <= 32'h0000_0000;
                        rd_valid_out <= ~cur_q.write;
                        rd_data_out  <= dq_s2_q;
                        state_q      <= adc_pkg::ST_CAS_PRE;
                    end else begin
                        cnt_q <= cnt_q + 32'h0000_0001;
                    end
                end
                adc_pkg::ST_CAS_PRE: begin
                    // page mode: same row and same kind keeps the row open
                    pins_out.lower_byte_column_strobe_n <= 1'b1;
                    pins_out.upper_byte_column_strobe_n <= 1'b1;
                    if (req_valid_in && !ref_due_q && req_in.write == cur_q.write
                        && req_in.addr[19:10] == cur_q.addr[19:10]) begin
                        cur_q         <= req_in;
                        req_ready_out <= 1'b1;
                        dq_out        <= req_in.wdata;
                        pins_out.addr <= req_in.addr[9:0];
                        state_q       <= adc_pkg::ST_ACCESS;
                    end else begin
                        state_q <= adc_pkg::ST_PRE;
                    end
                end
                default: begin
                    state_q <= adc_pkg::ST_PRE;
                end
            endcase
        end
    end

    property p_wake_wait;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_q == adc_pkg::ST_WAKE) |-> pins_out.ras_n && !init_done_out;
    endproperty
    a_wake_wait: assert property (p_wake_wait) else $error("strobe during wake wait");

    property p_early_write;
        @(posedge clk_in) disable iff (!rst_n_in)
        $fell(pins_out.lower_byte_column_strobe_n) && !pins_out.ras_n |-> cur_q.write == !pins_out.we_n;
    endproperty
    a_early_write: assert property (p_early_write) else $error("write strobe not set before column");

    property p_read_we_high;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(pins_out.ras_n) && !cur_q.write |-> pins_out.we_n;
    endproperty
    a_read_we_high: assert property (p_read_we_high) else $error("write strobe low in read");

    property p_cbr_order;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_q == adc_pkg::ST_CBR_RAS) |-> !pins_out.lower_byte_column_strobe_n;
    endproperty
    a_cbr_order: assert property (p_cbr_order) else $error("column strobe high in refresh");

    property p_precharge;
        @(posedge clk_in) disable iff (!rst_n_in)
        $rose(pins_out.ras_n) |-> pins_out.ras_n [*3];
    endproperty
    a_precharge: assert property (p_precharge) else $error("row precharge too short");

    property p_write_gate;
        @(posedge clk_in) disable iff (!rst_n_in)
        dq_oe_out |-> pins_out.oe_n;
    endproperty
    a_write_gate: assert property (p_write_gate) else $error("gate low while driving data");
endmodule : adc_ctrl

// ==== adc_dram_model.sv ====
`timescale 1ns/100ps
module adc_dram_model #(
    parameter int MAX_GAP_NS = 6000
) (
    input  wire adc_pkg::adc_pins_s pins_in,       // strobes and address
    input  wire logic [15:0]        dq_host_in,    // data from host
    output logic [15:0]             dq_out,        // data to host
    output int                      refreshes_out, // refresh cycles seen
    output int                      viol_out       // host timing faults
);
    logic [15:0] mem [0:1048575];
    logic [15:0] rd_q      = 16'h0000;
    logic [9:0]  row_q     = 10'h000;
    logic        rd_mode_q = 1'b0;
    realtime     last_ref_q = 0;
    wire  [1:0]  lane_on = {~pins_in.upper_byte_column_strobe_n, ~pins_in.lower_byte_column_strobe_n};
    wire         cas_n   = ~|lane_on;
    initial begin
        refreshes_out = 0;
        viol_out = 0;
    end
    // no pull-ups: a released lane shows the inverse of its last value
    assign dq_out[15:8] = (lane_on[1] && rd_mode_q) ? rd_q[15:8] : ~rd_q[15:8];
    assign dq_out[7:0]  = (lane_on[0] && rd_mode_q) ? rd_q[7:0] : ~rd_q[7:0];
    always @(negedge pins_in.ras_n) begin
        if (cas_n === 1'b0) begin
            if (refreshes_out > 0 && $realtime - last_ref_q > MAX_GAP_NS) viol_out++;
            refreshes_out++;
            last_ref_q = $realtime;
        end else begin
            row_q = pins_in.addr;
        end
    end
    always @(negedge cas_n) begin
        if (pins_in.ras_n === 1'b0) begin
            if (refreshes_out < 8) viol_out++;
            rd_mode_q = pins_in.we_n;
            if (pins_in.we_n === 1'b0) begin
                if (lane_on[0]) mem[{row_q, pins_in.addr}][7:0] = dq_host_in[7:0];
                if (lane_on[1]) mem[{row_q, pins_in.addr}][15:8] = dq_host_in[15:8];
            end else begin
                rd_q <= #13 mem[{row_q, pins_in.addr}];
            end
        end
    end
    // only early writes are legal against this model
    always @(negedge pins_in.we_n) begin
        if (cas_n === 1'b0) viol_out++;
    end
endmodule : adc_dram_model

// ==== adc_ctrl_tb.sv ====
`timescale 1ns/100ps
module adc_ctrl_tb;
    typedef struct { adc_pkg::adc_req_s req; logic [15:0] exp; } adc_row_s;
    logic               clk_in, rst_n, req_valid, req_ready, rd_valid, init_done, dq_oe;
    logic [15:0]        rd_data, dq_host, dq_dev;
    adc_pkg::adc_req_s  req;
    adc_pkg::adc_pins_s pins;
    int                 refreshes, viol, failures = 0, checks = 0, opens = 0;
    adc_row_s rows [10] = '{
        '{{1'b1, 2'b11, 20'h0_0401, 16'h1234}, 16'h0000}, '{{1'b0, 2'b11, 20'h0_0401, 16'h0000}, 16'h1234},
        '{{1'b1, 2'b01, 20'h0_0401, 16'hABCD}, 16'h0000}, '{{1'b0, 2'b11, 20'h0_0401, 16'h0000}, 16'h12CD},
        '{{1'b1, 2'b10, 20'h0_0401, 16'h5A00}, 16'h0000}, '{{1'b0, 2'b11, 20'h0_0401, 16'h0000}, 16'h5ACD},
        '{{1'b1, 2'b11, 20'hF_FFFF, 16'hBEEF}, 16'h0000}, '{{1'b0, 2'b11, 20'hF_FFFF, 16'h0000}, 16'hBEEF},
        '{{1'b0, 2'b11, 20'h0_0401, 16'h0000}, 16'h5ACD}, '{{1'b0, 2'b10, 20'h0_0401, 16'h0000}, 16'h5A00}};
    adc_ctrl #(.WAKE_CYCLES(50), .REF_INTERVAL(200)) dut (.clk_in(clk_in), .rst_n_in(rst_n),
        .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready), .rd_valid_out(rd_valid),
        .rd_data_out(rd_data), .init_done_out(init_done), .pins_out(pins), .dq_out(dq_host),
        .dq_oe_out(dq_oe), .dq_in(dq_dev));
    adc_dram_model mdl (.pins_in(pins), .dq_host_in(dq_host), .dq_out(dq_dev), .refreshes_out(refreshes),
        .viol_out(viol));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // row opens for an access; refreshes drop the row strobe with column strobes low
    always @(negedge pins.ras_n) begin
        if (pins.lower_byte_column_strobe_n && pins.upper_byte_column_strobe_n) opens++;
    end
    task automatic finish_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // bounded wait, sampled at the rising edge
    task automatic wait_hi(input int sel, input int lim, output int n);
        n = 0;
        while ((sel == 0 ? init_done : sel == 1 ? req_ready : rd_valid) !== 1'b1 && n < lim) begin
            @(posedge clk_in);
            n++;
        end
        if (n >= lim) begin
            failures++;
            $display("unexpected timeout on wait %0d", sel);
            finish_test();
        end
    endtask : wait_hi
    task automatic do_req(input adc_pkg::adc_req_s r, output logic [15:0] d);
        int n;
        req = r;
        req_valid = 1'b1;
        @(posedge clk_in);
        wait_hi(1, 60, n);
        #1 req_valid = 1'b0;
        if (!r.write) begin
            wait_hi(2, 40, n);
            d = rd_data;
        end
        // one edge between requests: valid is never lowered and raised at once
        @(posedge clk_in);
        #1;
    endtask : do_req
    task automatic do_reset();
        int n;
        rst_n = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        check("reset pins", pins, 15'h7C00);
        check("reset init", {init_done, dq_oe}, 2'b00);
        rst_n = 1'b1;
        wait_hi(0, 2000, n);
        check("wake length", n > 54, 1'b1);
        check("wake refreshes", refreshes >= 8, 1'b1);
        #1;
    endtask : do_reset
    initial begin
        logic [15:0] d, m;
        int          r0;
        req_valid = 1'b0;
        req = '0;
        do_reset();
        $display("test reset done");
        foreach (rows[i]) begin
            do_req(rows[i].req, d);
            m = {{8{rows[i].req.byte_en[1]}}, {8{rows[i].req.byte_en[0]}}};
            if (!rows[i].req.write) check("read data", d & m, rows[i].exp & m);
        end
        $display("test rows done");
        r0 = refreshes;
        repeat (1000) @(posedge clk_in);
        #1;
        check("idle refreshes", refreshes - r0 >= 4, 1'b1);
        $display("test refresh done");
        r0 = refreshes;
        do_reset();
        check("rewake refreshes", refreshes - r0 >= 8, 1'b1);
        do_req(rows[7].req, d);
        check("kept data", d, 16'hBEEF);
        r0 = opens;
        do_req('{1'b1, 2'b11, 20'h0_0402, 16'h1111}, d);
        do_req('{1'b1, 2'b11, 20'h0_0403, 16'h2222}, d);
        check("page opens", opens - r0, 1);
        do_req('{1'b0, 2'b11, 20'h0_0402, 16'h0000}, d);
        check("page first", d, 16'h1111);
        do_req('{1'b0, 2'b11, 20'h0_0403, 16'h0000}, d);
        check("page second", d, 16'h2222);
        $display("test page done");
        check("timing faults", viol, 0);
        $display("test rewake done");
        finish_test();
    end
endmodule : adc_ctrl_tb
